// ### rtl/fps_defs.vh
// Register offsets, fields, reset values and timing constants of the flash sequencer
`ifndef FPS_DEFS_VH
`define FPS_DEFS_VH

`define FPS_OFS_CTRL        8'h00
`define FPS_OFS_READCTRL    8'h04
`define FPS_OFS_WRITECTRL   8'h08
`define FPS_OFS_WRITECMD    8'h0C
`define FPS_OFS_ADDRB       8'h10
`define FPS_OFS_WDATA       8'h18
`define FPS_OFS_STATUS      8'h1C
`define FPS_OFS_IF          8'h2C
`define FPS_OFS_IFS         8'h30
`define FPS_OFS_IFC         8'h34
`define FPS_OFS_IEN         8'h38
`define FPS_OFS_LOCK        8'h3C
`define FPS_OFS_CMD         8'h40
`define FPS_OFS_HITS        8'h44
`define FPS_OFS_MISSES      8'h48
`define FPS_OFS_TIMEBASE    8'h50
`define FPS_OFS_MASSLOCK    8'h54
`define FPS_OFS_IRQLAT      8'h58

// Command register bits
`define FPS_CMD_LOAD_ADDR   0
`define FPS_CMD_ERASE_PAGE  1
`define FPS_CMD_WRITE_END   2
`define FPS_CMD_SINGLE_WR   3
`define FPS_CMD_DMA_TRIG    4
`define FPS_CMD_ERASE_ABORT 5
`define FPS_CMD_FULL_ERASE  8

// Status register bits
`define FPS_ST_BUSY         0
`define FPS_ST_LOCKED       1
`define FPS_ST_INVALID_ADDRESS_FLAG      2
`define FPS_ST_DATA_READY   3
`define FPS_ST_WR_TIMEOUT   4
`define FPS_ST_ERASE_ABORTED 5

// Timebase fields
`define FPS_TB_BASE_W       6
`define FPS_TB_PERIOD_BIT   16
`define FPS_TB_RESET        32'h00000010

`define FPS_CTRL_RESET      32'h00000001
`define FPS_READCTRL_RESET  32'h00000001
`define FPS_UNLOCK_KEY      16'h631A

// Flash geometry: 32 kB array, 1 kB pages
`define FPS_FLASH_BYTES     32'h00008000
`define FPS_PAGE_SHIFT      10
`define FPS_PAGES           32

// Pulse lengths in timebase periods
`define FPS_WRITE_TICKS     16'h0014
`define FPS_PERASE_TICKS    16'h0FA0
`define FPS_MERASE_TICKS    16'h2710

`endif

// ### rtl/fps_timebase.v
// Timebase tick generator counting aux timing clock enables
`timescale 1ns/1ns
module fps_timebase (
  // Clock and reset
  input  wire                   clk,
  input  wire                   rst_b,
  // Aux timing clock enable and setup
  input  wire                   aux_timing_en,
  input  wire [5:0]             base,
  input  wire                   long_period,
  input  wire                   run,
  // Tick out
  output reg                    tick
);
  reg [5:0] cyc_q;
  reg [2:0] sub_q;

  // One period is base+1 aux cycles; long period takes five of them
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_q <= 6'h00;
      sub_q <= 3'h0;
      tick  <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!run) begin
        cyc_q <= 6'h00;
        sub_q <= 3'h0;
      end else if (aux_timing_en) begin
        if (cyc_q == base) begin
          cyc_q <= 6'h00;
          if (!long_period || sub_q == 3'h4) begin
            sub_q <= 3'h0;
            tick  <= 1'b1;
          end else begin
            sub_q <= sub_q + 3'h1;
          end
        end else begin
          cyc_q <= cyc_q + 6'h01;
        end
      end
    end
  end
endmodule // fps_timebase

// ### rtl/fps_sequencer.v
// Flash program and erase sequencer with classic Wishbone register slave
`timescale 1ns/1ns
`include "fps_defs.vh"
module fps_sequencer (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  // System side
  input  wire        aux_timing_en,
  input  wire        deep_sleep_state,
  input  wire [31:0] page_lock_bits,
  input  wire        full_erase_lock_word,
  input  wire        unmapped_access,
  output wire        unmapped_bus_error,
  input  wire        flash_read_req,
  output wire        flash_read_stall,
  output wire        dma_request,
  // Flash array
  output reg         flash_prog,
  output reg         flash_page_erase,
  output reg         flash_full_erase,
  output reg  [14:0] flash_addr,
  output reg  [31:0] flash_wdata,
  input  wire [31:0] flash_rdata
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_WRITE = 2'b01;
  localparam ST_PERASE = 2'b10;
  localparam ST_MERASE = 2'b11;

  reg [1:0]  state_q;
  reg        fault_sel_q;
  reg [7:0]  readctrl_q;
  reg [1:0]  writectrl_q;
  reg [31:0] addrb_q;
  reg [31:0] addr_q;
  reg [31:0] wdata_q;
  reg        wdata_full_q;
  reg        invalid_address_flag_q;
  reg        locked_q;
  reg        aborted_q;
  reg        dma_mode_q;
  reg [3:0]  if_q;
  reg [3:0]  ien_q;
  reg        unlocked_q;
  reg [5:0]  tb_base_q;
  reg        tb_long_q;
  reg [15:0] ticks_q;
  reg [15:0] irqlat_q;
  wire       tick;

  wire       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire       wr       = req & wb_we_i;
  wire [31:0] cmd_bits = (wr && wb_adr_i == `FPS_OFS_WRITECMD) ? wb_dat_i : 32'h00000000;
  wire       busy     = (state_q != ST_IDLE);
  wire       data_ready = ~wdata_full_q;
  wire       page_lk  = page_lock_bits[addrb_q[`FPS_PAGE_SHIFT+4:`FPS_PAGE_SHIFT]];
  wire       op_ok    = ~invalid_address_flag_q & ~locked_q;
  wire       done_tick = tick && (ticks_q == 16'h0001);
  reg        mapped;

  fps_timebase u_timebase (
    .clk           (clk),
    .rst_b         (rst_b),
    .aux_timing_en (aux_timing_en),
    .base          (tb_base_q),
    .long_period   (tb_long_q),
    .run           (busy),
    .tick          (tick)
  );

  // Flash reads wait while the array is busy; RAM is not routed here
  assign flash_read_stall   = flash_read_req & busy;
  assign dma_request        = dma_mode_q & data_ready;
  assign unmapped_bus_error = unmapped_access & ~fault_sel_q;

  always @* begin
    case (wb_adr_i)
      `FPS_OFS_CTRL, `FPS_OFS_READCTRL, `FPS_OFS_WRITECTRL, `FPS_OFS_WRITECMD,
      `FPS_OFS_ADDRB, `FPS_OFS_WDATA, `FPS_OFS_STATUS, `FPS_OFS_IF, `FPS_OFS_IFS,
      `FPS_OFS_IFC, `FPS_OFS_IEN, `FPS_OFS_LOCK, `FPS_OFS_CMD, `FPS_OFS_HITS,
      `FPS_OFS_MISSES, `FPS_OFS_TIMEBASE, `FPS_OFS_MASSLOCK, `FPS_OFS_IRQLAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Bus answer: one cycle after the request, err for unmapped offsets
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & mapped;
      wb_err_o <= req & ~mapped;
      wb_dat_o <= 32'h00000000;
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          `FPS_OFS_CTRL:      wb_dat_o <= {31'h00000000, fault_sel_q};
          `FPS_OFS_READCTRL:  wb_dat_o <= {24'h000000, readctrl_q};
          `FPS_OFS_WRITECTRL: wb_dat_o <= {30'h00000000, writectrl_q};
          `FPS_OFS_ADDRB:     wb_dat_o <= addrb_q;
          `FPS_OFS_WDATA:     wb_dat_o <= wdata_q;
          `FPS_OFS_STATUS:    wb_dat_o <= {26'h0000000, aborted_q, 1'b0, data_ready,
                                           invalid_address_flag_q, locked_q, busy};
          `FPS_OFS_IF:        wb_dat_o <= {28'h0000000, if_q};
          `FPS_OFS_IEN:       wb_dat_o <= {28'h0000000, ien_q};
          `FPS_OFS_TIMEBASE:  wb_dat_o <= {15'h0000, tb_long_q, 10'h000, tb_base_q};
          `FPS_OFS_MASSLOCK:  wb_dat_o <= {31'h00000000, ~unlocked_q};
          `FPS_OFS_IRQLAT:    wb_dat_o <= {16'h0000, irqlat_q};
          default:            wb_dat_o <= 32'h00000000; // Command words read zero
        endcase
      end
    end
  end

  // Register file and sequencer
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q      <= ST_IDLE;
      fault_sel_q  <= 1'b1;
      readctrl_q   <= 8'h01;
      writectrl_q  <= 2'b00;
      addrb_q      <= 32'h00000000;
      addr_q       <= 32'h00000000;
      wdata_q      <= 32'h00000000;
      wdata_full_q <= 1'b0;
      invalid_address_flag_q    <= 1'b0;
      locked_q     <= 1'b0;
      aborted_q    <= 1'b0;
      dma_mode_q   <= 1'b0;
      if_q         <= 4'h0;
      ien_q        <= 4'h0;
      unlocked_q   <= 1'b0;
      tb_base_q    <= 6'h10;
      tb_long_q    <= 1'b0;
      ticks_q      <= 16'h0000;
      irqlat_q     <= 16'h0000;
      flash_prog   <= 1'b0;
      flash_page_erase <= 1'b0;
      flash_full_erase <= 1'b0;
      flash_addr   <= 15'h0000;
      flash_wdata  <= 32'hFFFFFFFF;
    end else begin
      if (wr) begin
        case (wb_adr_i)
          `FPS_OFS_CTRL:      fault_sel_q <= wb_dat_i[0];
          `FPS_OFS_READCTRL:  readctrl_q  <= wb_dat_i[7:0] & 8'h9F;
          `FPS_OFS_WRITECTRL: writectrl_q <= wb_dat_i[1:0];
          `FPS_OFS_ADDRB:     addrb_q     <= wb_dat_i;
          `FPS_OFS_IFS:       if_q        <= if_q | wb_dat_i[3:0];
          `FPS_OFS_IFC:       if_q        <= if_q & ~wb_dat_i[3:0];
          `FPS_OFS_IEN:       ien_q       <= wb_dat_i[3:0];
          `FPS_OFS_TIMEBASE: begin
            tb_base_q <= wb_dat_i[`FPS_TB_BASE_W-1:0];
            tb_long_q <= wb_dat_i[`FPS_TB_PERIOD_BIT];
          end
          `FPS_OFS_MASSLOCK:  unlocked_q  <= (wb_dat_i[15:0] == `FPS_UNLOCK_KEY);
          `FPS_OFS_IRQLAT:    irqlat_q    <= wb_dat_i[15:0];
          default: ;
        endcase
      end
      if (wr && wb_adr_i == `FPS_OFS_WDATA) begin
        wdata_q      <= wb_dat_i;
        wdata_full_q <= 1'b1;
      end
      if (cmd_bits[`FPS_CMD_LOAD_ADDR]) begin
        addr_q    <= addrb_q;
        invalid_address_flag_q <= (addrb_q >= `FPS_FLASH_BYTES);
        locked_q  <= (addrb_q < `FPS_FLASH_BYTES) & page_lk;
      end
      flash_prog <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cmd_bits[`FPS_CMD_SINGLE_WR] && op_ok && wdata_full_q) begin
            state_q      <= ST_WRITE;
            flash_addr   <= addr_q[14:0];
            flash_wdata  <= wdata_q; // Array ANDs into cell, ones keep old bits
            flash_prog   <= 1'b1;
            wdata_full_q <= 1'b0;
            ticks_q      <= `FPS_WRITE_TICKS;
            aborted_q    <= 1'b0;
          end else if (cmd_bits[`FPS_CMD_DMA_TRIG] && op_ok) begin
            dma_mode_q <= 1'b1;
          end else if (cmd_bits[`FPS_CMD_ERASE_PAGE] && op_ok) begin
            state_q          <= ST_PERASE;
            flash_addr       <= {addr_q[14:`FPS_PAGE_SHIFT], 10'h000};
            flash_page_erase <= 1'b1;
            ticks_q          <= `FPS_PERASE_TICKS;
            aborted_q        <= 1'b0;
          end else if (cmd_bits[`FPS_CMD_FULL_ERASE] && unlocked_q && !full_erase_lock_word) begin
            state_q          <= ST_MERASE;
            flash_full_erase <= 1'b1;
            ticks_q          <= `FPS_MERASE_TICKS;
            aborted_q        <= 1'b0;
          end
          // DMA stream: each arriving word starts the next program
          if (dma_mode_q && wdata_full_q && !cmd_bits[`FPS_CMD_SINGLE_WR]) begin
            state_q      <= ST_WRITE;
            flash_addr   <= addr_q[14:0];
            flash_wdata  <= wdata_q;
            flash_prog   <= 1'b1;
            wdata_full_q <= 1'b0;
            ticks_q      <= `FPS_WRITE_TICKS;
          end
          if (cmd_bits[`FPS_CMD_WRITE_END])
            dma_mode_q <= 1'b0;
        end
        ST_WRITE: begin
          if (done_tick) begin
            state_q <= ST_IDLE;
            addr_q  <= addr_q + 32'h00000004;
            if_q[0] <= 1'b1;
          end else if (tick) begin
            ticks_q <= ticks_q - 16'h0001;
          end
        end
        default: begin
          // Page or full erase; abort ends it at once
          if (cmd_bits[`FPS_CMD_ERASE_ABORT] || done_tick) begin
            state_q          <= ST_IDLE;
            flash_page_erase <= 1'b0;
            flash_full_erase <= 1'b0;
            aborted_q        <= cmd_bits[`FPS_CMD_ERASE_ABORT];
            if_q[1]          <= 1'b1;
          end else if (tick) begin
            ticks_q <= ticks_q - 16'h0001;
          end
        end
      endcase
      // Buffers are not retained in deep sleep
      if (deep_sleep_state) begin
        addrb_q      <= 32'h00000000;
        wdata_q      <= 32'h00000000;
        wdata_full_q <= 1'b0;
      end
    end
  end
endmodule // fps_sequencer

// ### test/fps_flash_model.sv
// Behavioural flash array facing the sequencer's flash port
`timescale 1ns/1ns
module fps_flash_model (
  // Clock
  input  logic        clk,
  // Flash port
  input  logic        flash_prog,
  input  logic        flash_page_erase,
  input  logic        flash_full_erase,
  input  logic [14:0] flash_addr,
  input  logic [31:0] flash_wdata,
  output logic [31:0] flash_rdata
);
  logic [31:0] mem [0:8191];
  logic        pe_q;
  logic        fe_q;
  int          i;
  initial begin
    for (i = 0; i < 8192; i++) mem[i] = 32'hFFFFFFFF;
    pe_q = 1'b0;
    fe_q = 1'b0;
  end
  assign flash_rdata = mem[flash_addr[14:2]];
  always @(posedge clk) begin
    // Cells only ever lose ones when programmed
    if (flash_prog) mem[flash_addr[14:2]] <= mem[flash_addr[14:2]] & flash_wdata;
    // Wiped at erase start, so an abort still leaves the page blank
    if (flash_page_erase && !pe_q) begin
      for (i = 0; i < 256; i++) mem[{flash_addr[14:10], i[7:0]}] <= 32'hFFFFFFFF;
    end
    if (flash_full_erase && !fe_q) begin
      for (i = 0; i < 8192; i++) mem[i] <= 32'hFFFFFFFF;
    end
    pe_q <= flash_page_erase;
    fe_q <= flash_full_erase;
  end
endmodule // fps_flash_model

// ### test/fps_sequencer_asserts.sv
// Port checker for the flash sequencer
`timescale 1ns/1ns
module fps_sequencer_asserts (
  input logic        clk,
  input logic        rst_b,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [7:0]  wb_adr_i,
  input logic [31:0] wb_dat_i,
  input logic        wb_ack_o,
  input logic        wb_err_o,
  input logic        unmapped_access,
  input logic        unmapped_bus_error,
  input logic        flash_read_req,
  input logic        flash_read_stall,
  input logic        dma_request,
  input logic        flash_prog,
  input logic        flash_page_erase,
  input logic        flash_full_erase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence wr_s(a);
    req_s ##0 (wb_we_i && wb_adr_i == a);
  endsequence
  bus_answer_a: assert property (req_s |=> (wb_ack_o ^ wb_err_o))
    else $error("bus request not answered once");
  ans_pulse_a: assert property ((wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o))
    else $error("bus answer longer than one cycle");
  ctrl_mapped_a: assert property (req_s ##0 (wb_adr_i == 8'h00) |=> wb_ack_o)
    else $error("control register access not acknowledged");
  fault_sel_a: assert property (unmapped_bus_error |-> unmapped_access)
    else $error("bus error without unmapped access");
  erase_stall_a: assert property (flash_read_req && (flash_page_erase || flash_full_erase) |-> flash_read_stall)
    else $error("flash read not stalled during erase");
  prog_stall_a: assert property (flash_read_req && flash_prog |-> flash_read_stall)
    else $error("flash read not stalled during program");
  prog_pulse_a: assert property (flash_prog |=> !flash_prog)
    else $error("program strobe longer than one cycle");
  data_clear_a: assert property (wr_s(8'h18) |=> !dma_request)
    else $error("data write left the DMA request up");
  erase_abort_a: assert property (wr_s(8'h0C) ##0 (wb_dat_i[5] && flash_page_erase) |-> ##[1:3] !flash_page_erase)
    else $error("erase kept running after abort");
endmodule // fps_sequencer_asserts
bind fps_sequencer fps_sequencer_asserts i_fps_sequencer_asserts (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .unmapped_access(unmapped_access), .unmapped_bus_error(unmapped_bus_error),
  .flash_read_req(flash_read_req), .flash_read_stall(flash_read_stall), .dma_request(dma_request),
  .flash_prog(flash_prog), .flash_page_erase(flash_page_erase), .flash_full_erase(flash_full_erase));

// ### test/testbench.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/1ns
module testbench;
  logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, sleep = 0, lockw = 0, unm = 0, e_r;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, plock = 0, rdat, fwd, frd, q_r;
  logic ack, err, ube, stall, dreq, fprog, fpe, ffe;
  logic [14:0] faddr;
  int n_mismatch = 0, tests_run = 0, n;
  always #50 clk = ~clk;
  fps_sequencer i_fps_sequencer (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .aux_timing_en(1'b1), .deep_sleep_state(sleep), .page_lock_bits(plock), .full_erase_lock_word(lockw),
    .unmapped_access(unm), .unmapped_bus_error(ube), .flash_read_req(1'b1), .flash_read_stall(stall),
    .dma_request(dreq), .flash_prog(fprog), .flash_page_erase(fpe), .flash_full_erase(ffe), .flash_addr(faddr),
    .flash_wdata(fwd), .flash_rdata(frd));
  fps_flash_model i_fps_flash_model (.clk(clk), .flash_prog(fprog), .flash_page_erase(fpe),
    .flash_full_erase(ffe), .flash_addr(faddr), .flash_wdata(fwd), .flash_rdata(frd));
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(string nm, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task bus(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do begin @(posedge clk); k++; end while (!(ack || err) && k < 50);
    q_r = rdat; e_r = err;
    if (!(ack || err)) begin
      n_mismatch++;
      $display("[FAIL] bus answer expected 1 seen 0");
    end
    cyc <= 0; stb <= 0;
  endtask
  task wr(logic [7:0] a, logic [31:0] d); bus(1, a, d); endtask
  task rdb(string nm, logic [7:0] a, int b, logic v); bus(0, a, 0); chk(nm, v, q_r[b]); endtask
  // Time a program by the stall it causes; slack covers command latency
  task op(int exp);
    n = 0;
    @(negedge clk);
    while (stall === 1'b1 && n < 2000) begin @(negedge clk); n++; end
    chk("op length", 1, n >= exp - 4 && n <= exp + 4);
  endtask
  task prog(logic [31:0] d, int exp); wr(8'h18, d); wr(8'h0C, 32'h8); op(exp); endtask
  task t_regs;
    bus(0, 8'h00, 0); chk("ctrl", 1, q_r);
    bus(0, 8'h50, 0); chk("timebase", 32'h10, q_r);
    bus(0, 8'h0C, 0); chk("cmd", 0, q_r);
    bus(1, 8'h14, 0); chk("unmapped err", 1, e_r);
    unm <= 1; @(negedge clk); chk("ube ignore", 0, ube);
    wr(8'h00, 0); @(negedge clk); chk("ube fault", 1, ube);
    wr(8'h00, 1); unm <= 0;
  endtask
  task t_prog;
    wr(8'h50, 32'h0A);
    wr(8'h10, 32'h100); wr(8'h0C, 32'h1);
    prog(32'hFFFFAAAA, 220); chk("w0", 32'hFFFFAAAA, i_fps_flash_model.mem[64]);
    rdb("busy", 8'h1C, 0, 0);
    prog(32'h5555FFFF, 220); chk("w1", 32'h5555FFFF, i_fps_flash_model.mem[65]);
    wr(8'h10, 32'h100); wr(8'h0C, 32'h1);
    prog(32'h5555FFFF, 220); chk("w0 twice", 32'h5555AAAA, i_fps_flash_model.mem[64]);
    wr(8'h50, 32'h1000A); prog(32'h0F0F0F0F, 1100); wr(8'h50, 32'h0A);
    chk("long word", 32'h05050F0F, i_fps_flash_model.mem[65]);
  endtask
  task t_lock;
    plock <= 32'h2; wr(8'h10, 32'h400); wr(8'h0C, 32'h1); rdb("locked", 8'h1C, 1, 1);
    wr(8'h18, 0); wr(8'h0C, 32'hA); repeat (3) @(negedge clk); chk("refused", 0, stall || fpe);
    wr(8'h10, 32'h8000); wr(8'h0C, 32'h1); rdb("invalid_address_flag", 8'h1C, 2, 1);
    wr(8'h0C, 32'h2); repeat (3) @(negedge clk); chk("refused", 0, fpe);
    plock <= 0; wr(8'h10, 32'h7FC); wr(8'h0C, 32'h1); wr(8'h0C, 32'h2); @(negedge clk);
    chk("erase", 1, fpe); chk("page", 1, faddr[14:10]);
    wr(8'h0C, 32'h20); repeat (3) @(negedge clk); chk("aborted", 0, fpe);
    rdb("abort flag", 8'h1C, 5, 1); rdb("idle", 8'h1C, 0, 0);
  endtask
  task t_dma;
    wr(8'h10, 32'h200); wr(8'h0C, 32'h1); wr(8'h18, 32'h12345678);
    rdb("ready clr", 8'h1C, 3, 0);
    wr(8'h0C, 32'h10); op(220);
    chk("dreq", 1, dreq); chk("d0", 32'h12345678, i_fps_flash_model.mem[128]);
    wr(8'h18, 32'h87654321); op(220);
    chk("d1", 32'h87654321, i_fps_flash_model.mem[129]);
    wr(8'h0C, 32'h4); wr(8'h10, 32'h300); sleep <= 1; @(posedge clk); sleep <= 0;
    bus(0, 8'h10, 0); chk("addrb lost", 0, q_r); bus(0, 8'h18, 0); chk("data lost", 0, q_r);
  endtask
  task t_irq;
    wr(8'h34, 32'h3); bus(0, 8'h2C, 0); chk("if clr", 0, q_r[1:0]);
    wr(8'h30, 32'h1); wr(8'h30, 0); bus(0, 8'h2C, 0); chk("if set", 1, q_r[1:0]);
    wr(8'h34, 32'h2); wr(8'h34, 32'h1); bus(0, 8'h2C, 0); chk("if clr1", 0, q_r[1:0]);
  endtask
  task t_full;
    wr(8'h0C, 32'h100); @(negedge clk); chk("locked full", 0, ffe);
    wr(8'h54, 32'h631A); rdb("unlocked", 8'h54, 0, 0);
    lockw <= 1; wr(8'h0C, 32'h100); @(negedge clk); chk("word lock", 0, ffe);
    lockw <= 0; plock <= 32'hFFFFFFFF; wr(8'h0C, 32'h100); @(negedge clk); chk("full", 1, ffe);
    wr(8'h54, 0); rdb("relocked", 8'h54, 0, 1); chk("still", 1, ffe);
    chk("wiped", 32'hFFFFFFFF, i_fps_flash_model.mem[64]);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1;
    t_regs; t_prog; t_lock; t_dma; t_irq; t_full;
    print_verdict;
  end
  // Whole run needs about 2500 cycles
  initial begin
    #(20000 * 100);
    n_mismatch++;
    print_verdict;
  end
endmodule // testbench
